// [adc_ctrl_pkg.sv]
// Constants shared by the dual converter read-out logic
// Overview of operation
// - Twelve-bit three-state result bus, bit 11 MSB
// - Bipolar variants deliver two's complement results
// - Unipolar variant delivers straight binary results
// - Trigger falling edge holds and starts both
// - Busy rises on trigger falling edge
// - Busy stays high until both conversions finish
// - Reads count only while select held low
// - Data driven only while select and strobe low
// - Pair low: reads give A1 then A2
// - Pair high: reads give B1 then B2
// - Conversion within 3.6 us or 6 us
package adc_ctrl_pkg;
    localparam int          RESULT_W       = 12;
    localparam int          MSB_POS        = 11;
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          CONV_HIGH_NS   = 3600;
    localparam int          CONV_SLEEP_NS  = 6000;
    // Longest times round down to whole cycles
    localparam int          CONV_HIGH_CYC  = CONV_HIGH_NS / CLK_PERIOD_NS;
    localparam int          CONV_SLEEP_CYC = CONV_SLEEP_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  STEP_HIGH      = 4'(CONV_HIGH_CYC / RESULT_W);
    localparam logic [3:0]  STEP_SLEEP     = 4'(CONV_SLEEP_CYC / RESULT_W);
    localparam logic [3:0]  LAST_BIT       = 4'(MSB_POS);
    localparam logic [11:0] FIRST_TRIAL    = 12'h800;
    localparam logic [11:0] RESULT_RESET   = 12'h000;
    localparam logic        TRIGGER_IDLE   = 1'b1;
endpackage

// [sar_if.sv]
// Handshake between the control logic and one approximation register
`timescale 1ns/10ps
`default_nettype none
interface sar_if;
    logic        start;
    logic        stepEn;
    logic        compareHigh;
    logic [11:0] trialCode;
    logic        done;
    logic [11:0] result;
    modport ctrl (output start, output stepEn, output compareHigh, input trialCode, input done, input result);
    modport conv (input start, input stepEn, input compareHigh, output trialCode, output done, output result);
endinterface
`default_nettype wire

// [sar_converter.sv]
// Successive approximation register for one converter
`timescale 1ns/10ps
`default_nettype none
module sar_converter (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    sar_if.conv       port
);
    typedef enum logic {IDLE, CONVERT} sarState_t;
    sarState_t  state;
    logic [3:0] bitIdx;
    logic       lastStep;
    logic [11:0] bitMask;
    logic [11:0] keptCode;

    assign bitMask  = 12'h001 << bitIdx;
    assign lastStep = (state == CONVERT) && port.stepEn && (bitIdx == 4'h0);
    // Comparator low means the trial bit overshoots and is dropped
    assign keptCode = port.compareHigh ? port.trialCode : (port.trialCode & ~bitMask);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state          <= IDLE;
            bitIdx         <= 4'h0;
            port.trialCode <= adc_ctrl_pkg::RESULT_RESET;
            port.result    <= adc_ctrl_pkg::RESULT_RESET;
            port.done      <= 1'b0;
        end else begin
            port.done <= lastStep;
            unique case (state)
                IDLE: begin
                    if (port.start) begin
                        state          <= CONVERT;
                        bitIdx         <= adc_ctrl_pkg::LAST_BIT;
                        port.trialCode <= adc_ctrl_pkg::FIRST_TRIAL;
                    end
                end
                CONVERT: begin
                    if (port.stepEn) begin
                        if (bitIdx == 4'h0) begin
                            state       <= IDLE;
                            port.result <= keptCode;
                        end else begin
                            bitIdx         <= bitIdx - 4'h1;
                            port.trialCode <= keptCode | (bitMask >> 1);
                        end
                    end
                end
            endcase
        end
    end

    sar_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state == CONVERT && port.stepEn && bitIdx != 4'h0) |=> bitIdx == $past(bitIdx) - 4'h1)
        else $error("approximation step skipped a bit");
endmodule
`default_nettype wire

// [dual_adc_parallel_read_ctrl.sv]
// Control and parallel read-out of a dual simultaneous-sampling converter
`timescale 1ns/10ps
`default_nettype none
module dual_adc_parallel_read_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        conversion_trigger_n,
    input  wire logic        selectN,
    input  wire logic        readN,
    input  wire logic        pair_select,
    input  wire logic        autoSleep,
    input  wire logic        bipolarRange,
    input  wire logic        compareHigh1,
    input  wire logic        compareHigh2,
    output logic [11:0]      trialCode1,
    output logic [11:0]      trialCode2,
    output logic             holdMode,
    output logic             muxPair,
    output logic             busy,
    output logic             result_bit_msb,
    output logic [3:0]       result_bits_upper,
    output logic [6:0]       result_bits_lower,
    output logic             dataOe
);
    sar_if conv1 ();
    sar_if conv2 ();

    logic        triggerPrev;
    logic        triggerFall;
    logic [3:0]  stepCount;
    logic [3:0]  stepPeriod;
    logic        stepEn;
    logic        done1;
    logic        done2;
    logic        bothDone;
    logic        readActive;
    logic        readActivePrev;
    logic        readEnd;
    logic        readIdx;
    logic        coding;
    logic [11:0] resultA1;
    logic [11:0] resultA2;
    logic [11:0] resultB1;
    logic [11:0] resultB2;
    logic [11:0] rawSel;
    logic [11:0] codedSel;
    logic [11:0] dataOut;
    logic [3:0]  next_stepCount;

    // Edge detect on the trigger; new triggers during busy are ignored
    assign triggerFall = triggerPrev && !conversion_trigger_n && !busy;
    assign stepPeriod  = autoSleep ? adc_ctrl_pkg::STEP_SLEEP : adc_ctrl_pkg::STEP_HIGH;
    assign stepEn      = busy && (stepCount == stepPeriod - 4'h1);
    assign bothDone    = (done1 || conv1.done) && (done2 || conv2.done);
    // First period one cycle short: done lags the last step, so busy spans exactly 12 periods
    assign next_stepCount = triggerFall ? 4'h1 : ((!busy || stepEn) ? 4'h0 : stepCount + 4'h1);

    assign conv1.start       = triggerFall;
    assign conv2.start       = triggerFall;
    assign conv1.stepEn      = stepEn;
    assign conv2.stepEn      = stepEn;
    assign conv1.compareHigh = compareHigh1;
    assign conv2.compareHigh = compareHigh2;
    assign trialCode1        = conv1.trialCode;
    assign trialCode2        = conv2.trialCode;
    assign holdMode          = busy;

    sar_converter u_conv1 (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .port    (conv1.conv)
    );
    sar_converter u_conv2 (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .port    (conv2.conv)
    );

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            triggerPrev <= adc_ctrl_pkg::TRIGGER_IDLE;
            busy        <= 1'b0;
            stepCount   <= 4'h0;
            done1       <= 1'b0;
            done2       <= 1'b0;
            muxPair     <= 1'b0;
            coding      <= 1'b0;
        end else begin
            triggerPrev <= conversion_trigger_n;
            stepCount   <= next_stepCount;
            if (triggerFall) begin
                busy    <= 1'b1;
                done1   <= 1'b0;
                done2   <= 1'b0;
                muxPair <= pair_select;
                coding  <= bipolarRange;
            end else if (busy && bothDone) begin
                busy  <= 1'b0;
                done1 <= 1'b0;
                done2 <= 1'b0;
            end else begin
                done1 <= done1 || conv1.done;
                done2 <= done2 || conv2.done;
            end
        end
    end

    // Results are kept per pair so either pair can be read back
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            resultA1 <= adc_ctrl_pkg::RESULT_RESET;
            resultA2 <= adc_ctrl_pkg::RESULT_RESET;
            resultB1 <= adc_ctrl_pkg::RESULT_RESET;
            resultB2 <= adc_ctrl_pkg::RESULT_RESET;
        end else if (busy && bothDone) begin
            if (muxPair) begin
                resultB1 <= conv1.result;
                resultB2 <= conv2.result;
            end else begin
                resultA1 <= conv1.result;
                resultA2 <= conv2.result;
            end
        end
    end

    // Read sequencing advances at the end of each selected strobe
    assign readActive = !selectN && !readN;
    assign readEnd    = readActivePrev && !readActive;
    assign dataOe     = readActive;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readActivePrev <= 1'b0;
            readIdx        <= 1'b0;
        end else begin
            readActivePrev <= readActive;
            if (triggerFall) begin
                readIdx <= 1'b0;
            end else if (readEnd) begin
                readIdx <= !readIdx;
            end
        end
    end

    assign rawSel   = pair_select ? (readIdx ? resultB2 : resultB1)
                                  : (readIdx ? resultA2 : resultA1);
    // Offset binary from the register; bipolar flips the MSB
    assign codedSel = coding ? {~rawSel[adc_ctrl_pkg::MSB_POS], rawSel[10:0]}
                             : rawSel;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dataOut <= adc_ctrl_pkg::RESULT_RESET;
        end else begin
            dataOut <= codedSel;
        end
    end

    assign result_bit_msb    = dataOut[adc_ctrl_pkg::MSB_POS];
    assign result_bits_upper = dataOut[10:7];
    assign result_bits_lower = dataOut[6:0];

    // Helper: busy length counter for timing checks
    logic [7:0] busyLen;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            busyLen <= 8'h00;
        end else begin
            busyLen <= busy ? busyLen + 8'h01 : 8'h00;
        end
    end

    sequence trigger_edge_s;
        $fell(conversion_trigger_n) && !busy;
    endsequence
    sequence busy_rise_s;
        ##1 busy && holdMode;
    endsequence

    busy_on_edge_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 trigger_edge_s |-> busy_rise_s)
        else $error("busy did not rise after trigger edge");
    hold_both_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ##1 trigger_edge_s |=> conv1.trialCode == 12'h800 && conv2.trialCode == 12'h800)
        else $error("converters did not start together");
    busy_length_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        busy |-> busyLen < 8'(adc_ctrl_pkg::CONV_SLEEP_CYC))
        else $error("conversion exceeded its time");
    high_mode_time_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(busy) && !autoSleep |-> $past(busyLen) == 8'(adc_ctrl_pkg::CONV_HIGH_CYC - 1))
        else $error("high mode conversion time wrong");
    busy_until_done_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(busy) |-> $past(bothDone))
        else $error("busy fell before both conversions finished");
    output_enable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        dataOe == (!selectN && !readN))
        else $error("data driven outside select and strobe");
    read_advance_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readEnd && !triggerFall |=> readIdx != $past(readIdx))
        else $error("read sequence did not advance");
    unselected_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        selectN && !readEnd && !triggerFall |=> $stable(readIdx))
        else $error("read counted without select");
    pair_b_first_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pair_select && !readIdx && !coding |=> dataOut == $past(resultB1))
        else $error("pair high first read not B1");
    pair_b_second_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pair_select && readIdx && !coding |=> dataOut == $past(resultB2))
        else $error("pair high second read not B2");
    pair_a_second_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !pair_select && readIdx && !coding |=> dataOut == $past(resultA2))
        else $error("pair low second read not A2");
    twos_comp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        coding && !pair_select && !readIdx |=> dataOut[11] != $past(resultA1[11]))
        else $error("bipolar coding not applied");
    // A retrigger mid-conversion must not relatch pair or coding
    retrigger_ignored_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        busy && $fell(conversion_trigger_n) |=> $stable(muxPair) && $stable(coding))
        else $error("trigger during conversion was taken");
    read_restart_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        triggerFall |=> !readIdx)
        else $error("read sequence not restarted by trigger");
endmodule
`default_nettype wire

// [analog_front_model.sv]
// Comparator model standing in for the four analog inputs
`timescale 1ns/10ps
`default_nettype none
module analog_front_model #(
    parameter logic [11:0] LEVEL_A1 = 12'h000,
    parameter logic [11:0] LEVEL_A2 = 12'h000,
    parameter logic [11:0] LEVEL_B1 = 12'h000,
    parameter logic [11:0] LEVEL_B2 = 12'h000
) (
    input  wire logic        holdMode,
    input  wire logic        muxPair,
    input  wire logic [11:0] trialCode1,
    input  wire logic [11:0] trialCode2,
    output logic             compareHigh1,
    output logic             compareHigh2
);
    wire [11:0] level1 = muxPair ? LEVEL_B1 : LEVEL_A1;
    wire [11:0] level2 = muxPair ? LEVEL_B2 : LEVEL_A2;
    wire        above1 = level1 >= trialCode1;
    wire        above2 = level2 >= trialCode2;
    // Tracking inputs give no usable decision, so answer wrongly
    assign compareHigh1 = holdMode ? above1 : ~above1;
    assign compareHigh2 = holdMode ? above2 : ~above2;
endmodule
`default_nettype wire

// [dual_adc_parallel_read_ctrl_tb_top.sv]
// Bench for the dual converter control and read-out
`timescale 1ns/10ps
`default_nettype none
module dual_adc_parallel_read_ctrl_tb_top;
    localparam logic [11:0] A1 = 12'h5A3;
    localparam logic [11:0] A2 = 12'hE17;
    localparam logic [11:0] B1 = 12'h0C4;
    localparam logic [11:0] B2 = 12'hF80;
    logic        refClk     = 1'b0;
    logic        sysRst     = 1'b1;
    logic        trigN      = 1'b1;
    logic        selectN    = 1'b1;
    logic        readN      = 1'b1;
    logic        pairSel    = 1'b0;
    logic        autoSleep  = 1'b0;
    logic        bipolar    = 1'b0;
    logic        cmp1, cmp2, holdMode, muxPair, busy, msb, dataOe;
    logic [11:0] trial1, trial2;
    logic [3:0]  upper;
    logic [6:0]  lower;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    wire  [11:0] dataBus    = {msb, upper, lower};

    dual_adc_parallel_read_ctrl DUT (.ref_clk(refClk), .sys_rst(sysRst), .conversion_trigger_n(trigN),
        .selectN(selectN), .readN(readN), .pair_select(pairSel), .autoSleep(autoSleep),
        .bipolarRange(bipolar), .compareHigh1(cmp1), .compareHigh2(cmp2), .trialCode1(trial1),
        .trialCode2(trial2), .holdMode(holdMode), .muxPair(muxPair), .busy(busy),
        .result_bit_msb(msb), .result_bits_upper(upper), .result_bits_lower(lower), .dataOe(dataOe));
    analog_front_model #(.LEVEL_A1(A1), .LEVEL_A2(A2), .LEVEL_B1(B1), .LEVEL_B2(B2)) front (
        .holdMode(holdMode), .muxPair(muxPair), .trialCode1(trial1), .trialCode2(trial2),
        .compareHigh1(cmp1), .compareHigh2(cmp2));

    always #25 refClk = ~refClk;

    // Whole run needs well under a thousand cycles
    always @(posedge refClk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Converter core is offset binary; bipolar flips the top bit
    function automatic logic [11:0] enc(input logic [11:0] x, input logic bip);
        return bip ? x ^ 12'h800 : x;
    endfunction

    // Poke pulses the trigger again mid-conversion, which must be ignored
    task automatic convert(input logic pair, input logic sleep, input logic bip, input bit poke);
        int n;
        int cyc;
        cyc = sleep ? adc_ctrl_pkg::CONV_SLEEP_CYC : adc_ctrl_pkg::CONV_HIGH_CYC;
        n = 0;
        @(negedge refClk);
        pairSel = pair;
        autoSleep = sleep;
        bipolar = bip;
        trigN = 1'b0;
        repeat (2) begin
            @(negedge refClk);
            n += int'(busy);
        end
        check("busy rise", {11'h000, busy}, 12'h001);
        check("hold", {11'h000, holdMode}, 12'h001);
        check("held pair", {11'h000, muxPair}, {11'h000, pair});
        trigN = 1'b1;
        while (busy === 1'b1 && n < 200) begin
            @(negedge refClk);
            n += int'(busy);
            if (poke && n == 5) trigN = 1'b0;
            if (poke && n == 8) trigN = 1'b1;
        end
        check("busy length", {11'h000, n >= cyc - 1 && n <= cyc}, 12'h001);
    endtask

    task automatic read_word(input string what, input logic [11:0] exp);
        @(negedge refClk);
        selectN = 1'b0;
        readN = 1'b0;
        repeat (2) @(negedge refClk);
        check("bus enable", {11'h000, dataOe}, 12'h001);
        check(what, dataBus, exp);
        readN = 1'b1;
        selectN = 1'b1;
        @(negedge refClk);
        check("bus release", {11'h000, dataOe}, 12'h000);
        repeat (2) @(negedge refClk);
    endtask

    task automatic test_pair_a();
        convert(1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge refClk);
        readN = 1'b0;
        repeat (2) @(negedge refClk);
        check("strobe unselected", {11'h000, dataOe}, 12'h000);
        readN = 1'b1;
        repeat (2) @(negedge refClk);
        read_word("A1", A1);
        read_word("A2", A2);
        read_word("A1 again", A1);
        $display("test pair_a done");
    endtask

    // Index left at input 2 must restart on the next trigger
    task automatic test_pair_b();
        convert(1'b1, 1'b1, 1'b1, 1'b1);
        read_word("B1", enc(B1, 1'b1));
        read_word("B2", enc(B2, 1'b1));
        $display("test pair_b done");
    endtask

    task automatic test_bipolar_a();
        convert(1'b0, 1'b0, 1'b1, 1'b0);
        read_word("A1 bipolar", enc(A1, 1'b1));
        read_word("A2 bipolar", enc(A2, 1'b1));
        $display("test bipolar_a done");
    endtask

    task automatic test_pair_b_unipolar();
        convert(1'b1, 1'b0, 1'b0, 1'b0);
        read_word("B1 unipolar", B1);
        read_word("B2 unipolar", B2);
        $display("test pair_b_unipolar done");
    endtask

    initial begin
        repeat (8) @(negedge refClk);
        sysRst = 1'b0;
        check("busy after reset", {11'h000, busy}, 12'h000);
        repeat (2) @(negedge refClk);
        test_pair_a();
        test_pair_b();
        test_bipolar_a();
        test_pair_b_unipolar();
        end_sim();
    end
endmodule
`default_nettype wire
